/* common/sic_pkg.sv */
/*
  Shared constants and types for the serial port setup block: register
  offsets, field positions, reset values, timing counts and carriers.
  Assumes a single 125 MHz core clock drives every user of this package.
*/
package sic_pkg;

  // Core clock period, used to turn times into cycle counts
  localparam int CLK_PERIOD_NS = 8;

  // Instruction and data widths on the serial line
  localparam int ADDR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int REG_AW    = 15;

  // Register offsets
  localparam logic [14:0] SETUP_A_ADDR = 15'h0000;
  localparam logic [14:0] SETUP_B_ADDR = 15'h0001;

  // Field positions of serial_port_setup_a
  localparam int A_REINIT   = 0;
  localparam int A_LSB      = 1;
  localparam int A_ASCEND   = 2;
  localparam int A_ASCEND_M = 5;
  localparam int A_LSB_M    = 6;
  localparam int A_REINIT_M = 7;

  // Field positions of serial_port_setup_b
  localparam int B_SINGLE   = 7;
  localparam int B_HOLD     = 6;
  localparam int B_CTRL_RB  = 5;

  // Reset values
  localparam logic [7:0] SETUP_A_RST = 8'h00;
  localparam logic [7:0] SETUP_B_RST = 8'h00;
  localparam logic [7:0] B_WR_MASK   = 8'he0;

  // Length of the soft reset pulse sent to the rest of the device
  localparam int REINIT_TIME_NS = 80;
  localparam int REINIT_CYCLES  = (REINIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial state: address phase or data phase
  typedef enum logic [0:0] {
    SIC_ST_ADDR = 1'b0,
    SIC_ST_DATA = 1'b1
  } sic_state_t;

  // Serial pins as seen by the core, already synchronous
  typedef struct packed {
    logic csn;
    logic sclk;
    logic sdio;
  } sic_pins_t;

  // Write request to the device registers outside this block
  typedef struct packed {
    logic        wr;
    logic [14:0] addr;
    logic [7:0]  data;
  } sic_regreq_t;

endpackage

/* verilog/sic_reinit_timer.sv */
/*
  Soft reset pulse timer: a start pulse opens a reset window of a fixed
  number of core clock cycles, and a one-cycle done pulse closes it.
  Assumes start_i is a single-cycle pulse in the core clock domain.
*/
`timescale 1ns/10ps

module sic_reinit_timer #(
  parameter int CYCLES = sic_pkg::REINIT_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic          busy_r;
  logic          done_r;
  wire           last_w = busy_r & (cnt_r == LAST);

  // Restart wins over the end of a running window
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      busy_r <= start_i | (busy_r & ~last_w);
      cnt_r  <= (start_i | last_w) ? '0 : (busy_r ? cnt_r + 1'b1 : cnt_r);
      done_r <= last_w & ~start_i;
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;

endmodule

/* verilog/sic_serial_setup.sv */
/*
  Serial port front end with its two setup registers: decodes 3-wire
  instructions, holds the mirrored setup register and the single
  instruction controls, and issues soft reset and register writes.
  Assumes pins arrive synchronous to core_clk_i and that the serial clock
  runs well below a quarter of the core clock.
*/
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Setup register A holds three control bits, mirrored in its upper nibble.
// - Bits 7,6,5 copy bits 0,1,2 and are readable and writable.
// - Streaming address steps up when bit 2 is set, down when clear.
// - Data bits shift LSB first when bit 1 is set, else MSB first.
// - Writing bit 0 soft-resets the device except register A and serial logic.
// - The soft reset bit clears itself once the reset has finished.
// - Single instruction bit 7 of register B limits each instruction to one byte.
// - In single mode the serial logic returns to idle after the data byte.
// - Instructions carry 16 bits, 15 of them address; the top bit set means readback.
// - Select low frames an instruction; data sampled on rising serial clock.
// - Readback drives the data line after the last address bit until select rises outside hold mode or a single instruction ends.
// - With single mode and hold bit 6 set, high select keeps serial state.
module sic_serial_setup (
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  input  wire sic_pkg::sic_pins_t  pins_i,
  input  wire logic [7:0]          reg_rdata_i,
  output logic                     sdio_o,
  output logic                     sdio_oe_o,
  output sic_pkg::sic_regreq_t     req_o,
  output logic                     reinit_o
);

  logic                 sclk_q_r;
  sic_pkg::sic_state_t  state_r;
  logic [3:0]           cnt_r;
  logic [14:0]          shift_r;
  logic [7:0]           dshift_r;
  logic [14:0]          addr_r;
  logic                 rd_r;
  logic [7:0]           cfg_a_r;
  logic [7:0]           cfg_b_r;
  logic                 sdio_r;
  logic                 oe_r;
  sic_pkg::sic_regreq_t req_r;
  logic                 reinit_busy;
  logic                 reinit_done;

  //////////////////////////////////////////////////////////////////////////
  // Decode of framing, edges and control bits
  wire single_w   = cfg_b_r[sic_pkg::B_SINGLE];
  wire hold_w     = single_w & cfg_b_r[sic_pkg::B_HOLD];
  wire lsb_w      = cfg_a_r[sic_pkg::A_LSB];
  wire ascend_w   = cfg_a_r[sic_pkg::A_ASCEND];
  wire frame_rst  = pins_i.csn & ~hold_w;
  wire rise_w     = pins_i.sclk & ~sclk_q_r & ~pins_i.csn;
  wire addr_done  = rise_w & (state_r == sic_pkg::SIC_ST_ADDR) & (cnt_r == 4'hf);
  wire byte_done  = rise_w & (state_r == sic_pkg::SIC_ST_DATA) & (cnt_r == 4'h7);
  wire [15:0] inst_w = {shift_r, pins_i.sdio};

  // Data byte assembly in either bit order
  wire [7:0] dbyte_w = lsb_w ? {pins_i.sdio, dshift_r[7:1]}
                             : {dshift_r[6:0], pins_i.sdio};

  // Next streaming address; wraps within the 15-bit space
  wire [14:0] addr_step = ascend_w ? addr_r + 15'h0001 : addr_r - 15'h0001;

  // Write decode of the data byte just completed
  wire wr_byte = byte_done & ~rd_r;
  wire wr_a    = wr_byte & (addr_r == sic_pkg::SETUP_A_ADDR);
  wire wr_b    = wr_byte & (addr_r == sic_pkg::SETUP_B_ADDR);
  wire wr_ext  = wr_byte & ~wr_a & ~wr_b;

  // Either half of the palindrome sets a bit, so a controller that lost
  // bit sync still lands on the intended setting
  wire [2:0] a_low_w = dbyte_w[2:0] | {dbyte_w[sic_pkg::A_ASCEND_M],
                                       dbyte_w[sic_pkg::A_LSB_M],
                                       dbyte_w[sic_pkg::A_REINIT_M]};

  // Readback byte selection
  wire [7:0] rd_byte = (addr_r == sic_pkg::SETUP_A_ADDR) ? cfg_a_r :
                       (addr_r == sic_pkg::SETUP_B_ADDR) ? cfg_b_r : reg_rdata_i;
  wire [2:0] bit_idx = lsb_w ? cnt_r[2:0] : 3'h7 - cnt_r[2:0];

  //////////////////////////////////////////////////////////////////////////
  // Serial state machine
  wire state_rst = frame_rst | (byte_done & single_w);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q_r <= 1'b0;
      state_r  <= sic_pkg::SIC_ST_ADDR;
      cnt_r    <= 4'h0;
    end else begin
      sclk_q_r <= pins_i.sclk;
      if (state_rst) begin
        state_r <= sic_pkg::SIC_ST_ADDR;
        cnt_r   <= 4'h0;
      end else if (addr_done) begin
        state_r <= sic_pkg::SIC_ST_DATA;
        cnt_r   <= 4'h0;
      end else if (rise_w) begin
        cnt_r   <= (state_r == sic_pkg::SIC_ST_DATA) ? {1'b0, cnt_r[2:0] + 3'h1} : cnt_r + 4'h1;
      end
    end
  end

  // Address and data shifters
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_r  <= '0;
      dshift_r <= 8'h00;
      addr_r   <= '0;
      rd_r     <= 1'b0;
    end else begin
      if (rise_w && state_r == sic_pkg::SIC_ST_ADDR) begin
        shift_r <= inst_w[14:0];
      end
      if (rise_w && state_r == sic_pkg::SIC_ST_DATA) begin
        dshift_r <= dbyte_w;
      end
      if (addr_done) begin
        rd_r   <= inst_w[15];
        addr_r <= inst_w[14:0];
      end else if (byte_done && !single_w) begin
        addr_r <= addr_step;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data line drive: on after the last address bit of a read, off when
  // select releases the frame or single mode ends the instruction
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_r   <= 1'b0;
      sdio_r <= 1'b0;
    end else begin
      if (state_rst) begin
        oe_r <= 1'b0;
      end else if (addr_done) begin
        oe_r <= inst_w[15];
      end
      sdio_r <= rd_byte[bit_idx];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Setup registers; a hardware clear of the reset bit loses to a write
  wire a_reinit_nxt = wr_a ? a_low_w[0] : (cfg_a_r[sic_pkg::A_REINIT] & ~reinit_done);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_a_r <= sic_pkg::SETUP_A_RST;
    end else begin
      // Upper copies run in reverse order: bit 6 mirrors bit 1, bit 5 mirrors bit 2
      cfg_a_r <= {a_reinit_nxt, (wr_a ? {a_low_w[1], a_low_w[2]} : {cfg_a_r[1], cfg_a_r[2]}),
                  2'b00,
                  (wr_a ? a_low_w[2:1] : cfg_a_r[2:1]), a_reinit_nxt};
    end
  end

  // Register B takes the soft reset; register A does not
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_b_r <= sic_pkg::SETUP_B_RST;
    end else if (reinit_busy) begin
      cfg_b_r <= sic_pkg::SETUP_B_RST;
    end else if (wr_b) begin
      cfg_b_r <= dbyte_w & sic_pkg::B_WR_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Soft reset window and writes to the rest of the device
  sic_reinit_timer #(
    .CYCLES (sic_pkg::REINIT_CYCLES)
  ) u_reinit (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .start_i    (wr_a & a_low_w[0]),
    .busy_o     (reinit_busy),
    .done_o     (reinit_done)
  );

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_r <= '0;
    end else begin
      req_r.wr <= wr_ext;
      if (wr_ext) begin
        req_r.addr <= addr_r;
        req_r.data <= dbyte_w;
      end
    end
  end

  assign sdio_o    = sdio_r;
  assign sdio_oe_o = oe_r;
  assign req_o     = req_r;
  assign reinit_o  = reinit_busy;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int REINIT_WAIT = sic_pkg::REINIT_CYCLES + 3;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_last_addr_read;
    addr_done && inst_w[15];
  endsequence

  sequence s_stream_byte;
    byte_done && !single_w;
  endsequence

  mirror_nibble_a: assert property (cfg_a_r[7:5] == {cfg_a_r[0], cfg_a_r[1], cfg_a_r[2]})
    else $error("setup A upper bits differ from lower bits");
  reserved_zero_a: assert property (cfg_a_r[4:3] == 2'b00)
    else $error("setup A reserved bits not zero");
  addr_up_a: assert property (s_stream_byte and ascend_w |=> addr_r == $past(addr_r) + 15'h0001)
    else $error("address did not step up");
  addr_down_a: assert property (s_stream_byte and !ascend_w |=> addr_r == $past(addr_r) - 15'h0001)
    else $error("address did not step down");
  read_drive_a: assert property (s_last_addr_read |=> sdio_oe_o)
    else $error("data line not driven after read address");
  select_release_a: assert property (frame_rst |=> !sdio_oe_o && state_r == sic_pkg::SIC_ST_ADDR)
    else $error("select high did not release the frame");
  single_idle_a: assert property (byte_done && single_w |=> state_r == sic_pkg::SIC_ST_ADDR && cnt_r == 4'h0)
    else $error("single instruction did not return to idle");
  hold_keep_a: assert property (pins_i.csn && hold_w |=> state_r == $past(state_r) && cnt_r == $past(cnt_r))
    else $error("held select reset the serial state");
  reinit_clear_a: assert property (wr_a && a_low_w[0] |=> cfg_a_r[0] ##[1:REINIT_WAIT] !cfg_a_r[0])
    else $error("soft reset bit did not clear");
  reinit_b_a: assert property (reinit_o |=> cfg_b_r == sic_pkg::SETUP_B_RST)
    else $error("soft reset did not clear setup B");

endmodule

/* sim/sic_spi_ctrl.sv */
/*
  Model of the 3-wire serial controller: frames instructions with select,
  drives serial clock and shared data line, samples the line on readback.
  Assumes the caller steps it from one testbench thread only.
*/
`timescale 1ns/10ps

module sic_spi_ctrl (
  input  wire logic          core_clk_i,
  input  wire logic          sdio_i,
  input  wire logic          sdio_oe_i,
  output sic_pkg::sic_pins_t pins_o
);
  logic csn_r  = 1'b1;
  logic sclk_r = 1'b0;
  logic drv_r  = 1'b0;
  logic bit_r  = 1'b0;
  logic last_r = 1'b0;
  wire  line;

  //////////////////////////////////////////////////////////////////////////////
  // Undriven line flips each cycle so a stale value never passes
  assign line   = sdio_oe_i ? sdio_i : (drv_r ? bit_r : ~last_r);
  assign pins_o = '{csn: csn_r, sclk: sclk_r, sdio: line};
  always @(posedge core_clk_i) begin
    last_r <= line;
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Select only moves while the clock rests low
  task automatic sel(input logic lvl);
    wait_c(1);
    sclk_r = 1'b0;
    drv_r  = 1'b0;
    wait_c(2);
    csn_r = lvl;
    wait_c(3);
  endtask

  // Shifts n bits of v, first bit v[n-1]; collects line before each rise
  task automatic shift(input int n, input logic [31:0] v, input logic drv, output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_r = 1'b0;
      drv_r  = drv;
      bit_r  = v[i];
      wait_c(2);
      got    = {got[30:0], line};
      sclk_r = 1'b1;
      wait_c(1);
      if (i == 0) begin
        drv_r = 1'b0;
      end
      wait_c(1);
    end
  endtask
endmodule

/* sim/sic_serial_setup_tb.sv */
/*
  Self-checking bench for the serial setup block: register accesses by
  serial frames, streaming, bit order, soft reset, single and hold modes.
  Assumes the controller model sic_spi_ctrl sits on the serial pins.
*/
`timescale 1ns/10ps

module sic_serial_setup_tb;
  logic               clk;
  logic               rstn;
  logic [7:0]         rdata;
  sic_pkg::sic_pins_t pins;
  logic               sdio;
  logic               sdio_oe;
  sic_pkg::sic_regreq_t req;
  logic               reinit;
  logic [22:0]        wq[$];
  logic [31:0]        g;
  int                 err_count = 0;
  int                 cmp_count = 0;
  int                 rcnt = 0;

  sic_serial_setup dut_u (
    .core_clk_i  (clk),
    .rstn_i      (rstn),
    .pins_i      (pins),
    .reg_rdata_i (rdata),
    .sdio_o      (sdio),
    .sdio_oe_o   (sdio_oe),
    .req_o       (req),
    .reinit_o    (reinit)
  );
  sic_spi_ctrl ctrl_u (
    .core_clk_i (clk),
    .sdio_i     (sdio),
    .sdio_oe_i  (sdio_oe),
    .pins_o     (pins)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Clock, outside write log and soft reset length count
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (req.wr === 1'b1 && req.addr > 15'h0001) wq.push_back({req.addr, req.data});
    if (reinit === 1'b1) rcnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction

  // Whole frames: address, then nb data bytes
  task automatic wr(input logic [14:0] a, input logic [15:0] d, input int nb);
    logic [31:0] x;
    ctrl_u.sel(1'b0);
    ctrl_u.shift(16, {17'h00000, a}, 1'b1, x);
    ctrl_u.shift(8 * nb, {16'h0000, d}, 1'b1, x);
    ctrl_u.sel(1'b1);
  endtask

  task automatic rd(input logic [14:0] a, input int nb, output logic [31:0] x);
    ctrl_u.sel(1'b0);
    ctrl_u.shift(16, {16'h0000, 1'b1, a}, 1'b1, x);
    check({31'h0, sdio_oe}, 32'h1);
    ctrl_u.shift(8 * nb, 32'h0, 1'b0, x);
    ctrl_u.sel(1'b1);
    check({31'h0, sdio_oe}, 32'h0);
  endtask

  task automatic expw(input logic [14:0] a, input logic [7:0] d);
    logic [22:0] w;
    w = (wq.size() > 0) ? wq.pop_front() : 23'h7fffff;
    check({9'h000, w}, {9'h000, a, d});
  endtask

  // Watchdog: run needs roughly 2600 cycles
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn  = 1'b0;
    rdata = 8'h5a;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    rd(15'h0000, 1, g);
    check(g, {24'h0, sic_pkg::SETUP_A_RST});
    rd(15'h0001, 1, g);
    check(g, {24'h0, sic_pkg::SETUP_B_RST});
    wr(15'h0000, 16'h003c, 1);
    rd(15'h0000, 1, g);
    check(g, 32'h24);
    wr(15'h0010, 16'h1122, 2);
    expw(15'h0010, 8'h11);
    expw(15'h0011, 8'h22);
    wr(15'h0000, 16'h0000, 1);
    wr(15'h0010, 16'h3344, 2);
    expw(15'h0010, 8'h33);
    expw(15'h000f, 8'h44);
    wr(15'h0000, 16'h0042, 1);
    wr(15'h0020, {8'h00, rev8(8'ha1)}, 1);
    expw(15'h0020, 8'ha1);
    rd(15'h0000, 1, g);
    check({24'h0, rev8(g[7:0])}, 32'h42);
    wr(15'h0000, 16'h0000, 1);
    rd(15'h0030, 2, g);
    check(g, 32'h5a5a);
    // Outside readback byte changes between frames
    rdata = 8'h96;
    rd(15'h0031, 1, g);
    check(g, 32'h96);
    // Soft reset clears B, keeps A setting, bit 0 clears itself
    wr(15'h0001, 16'h0020, 1);
    rcnt = 0;
    wr(15'h0000, 16'h0081, 1);
    rd(15'h0000, 1, g);
    check(g, 32'h0);
    check(rcnt, sic_pkg::REINIT_CYCLES);
    rd(15'h0001, 1, g);
    check(g, 32'h0);
    // Partial instruction at select rise is dropped
    ctrl_u.sel(1'b0);
    ctrl_u.shift(8, 32'h0, 1'b1, g);
    ctrl_u.sel(1'b1);
    wr(15'h0060, 16'h0012, 1);
    expw(15'h0060, 8'h12);
    // Single mode: second instruction inside one select frame
    wr(15'h0001, 16'h0080, 1);
    ctrl_u.sel(1'b0);
    ctrl_u.shift(24, 32'h004055, 1'b1, g);
    ctrl_u.shift(24, 32'h004166, 1'b1, g);
    ctrl_u.sel(1'b1);
    expw(15'h0040, 8'h55);
    expw(15'h0041, 8'h66);
    // Hold: select pulse in mid address keeps state
    wr(15'h0001, 16'h00c0, 1);
    ctrl_u.sel(1'b0);
    ctrl_u.shift(8, 32'h0, 1'b1, g);
    ctrl_u.sel(1'b1);
    ctrl_u.sel(1'b0);
    ctrl_u.shift(16, 32'h5077, 1'b1, g);
    ctrl_u.sel(1'b1);
    expw(15'h0050, 8'h77);
    check(wq.size(), 32'h0);
    tally_and_finish();
  end
endmodule
